// ---- verilog/appc_chain.sv ----
// Operation
// [RULE1] Average 1 to 128 samples, power-of-two select
// [RULE2] Refresh period 32 us doubling per code
// [RULE3] IIR filter only when enabled, else bypass
// [RULE4] Linear temperature drift correction, factory defaults
// [RULE5] Direction select makes angle increase
// [RULE6] Subtract pre-scale zero before gain
// [RULE7] Short stroke: flag above and below bounds
// [RULE8] Short stroke: gain spreads stroke over codes
// [RULE9] Harmonic correction from coefficients when enabled
// [RULE10] Subtract pre-linearize zero before segmented correction
// [RULE11] Segmented correction from coefficients when enabled
// [RULE12] Subtract post-linearize zero after linearization
// [RULE13] Final polarity flip negates angle
// [RULE14] Short stroke: clamp to output limits
// [RULE15] 16-bit arithmetic, rounded to 12 bits
// [RULE16] Short stroke inversion: upper minus (angle minus lower)
// [RULE17] Die adjust rotates by half turn
// [RULE18] Decimate and band-pass front-end samples
// [RULE19] One raw angle per conditioned sample
// [RULE20] Disabled stages skipped to cut latency
// [RULE21] Offsets and rotation wrap modulo full turn
// [RULE22] Round adds half then wraps 12 bits
`timescale 1ns/10ps
`default_nettype none

module appc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             empty;
  logic             full;
  logic             push;
  logic             pop;

  // Depth must be a power of two for the wrap bit
  assign empty        = (wr_ptr == rd_ptr);
  assign full         = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out = !full;
  assign push         = in_valid_in && !full;
  assign pop          = !empty && (!out_valid_out || out_ready_in);

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem[rd_ptr[AW-1:0]];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end

endmodule // appc_fifo

module appc_chain (
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 resetn_in,
  // Front end
  output logic                      fe_sample_req_out,
  input  wire logic                 fe_valid_in,
  input  wire appc_pkg::appc_fe_s   fe_sample_in,
  input  wire logic [11:0]          temperature_in,
  // Configuration
  input  wire appc_pkg::appc_cfg_s  cfg_in,
  input  wire appc_pkg::appc_zero_s zero_in,
  input  wire appc_pkg::appc_lim_s  lim_in,
  input  wire appc_pkg::appc_coef_t correction_coefficients_in,
  input  wire logic                 tc_load_in,
  input  wire appc_pkg::appc_tc_s   tc_in,
  // Fault flags
  input  wire logic                 fault_clear_in,
  output logic                      angle_above_limit_flag_out,
  output logic                      angle_below_limit_flag_out,
  // Processed angle
  output logic [11:0]               angle_out,
  output logic                      angle_valid_out,
  input  wire logic                 angle_ready_in
);
  import appc_pkg::*;

  function automatic logic signed [15:0] sin16(input logic [3:0] p);
    logic [2:0]         k;
    logic signed [15:0] m;
    k     = p[2] ? 3'(3'd4 - {1'b0, p[1:0]}) : {1'b0, p[1:0]};
    m     = SIN_Q[k];
    sin16 = p[3] ? -m : m;
  endfunction

  function automatic logic [11:0] round12(input logic [15:0] v);
    logic [15:0] s;
    s       = v + RND_HALF;
    round12 = s[15:RND_SH];
  endfunction

  function automatic logic stage_on(input appc_st_e s, input appc_cfg_s c);
    case (s)
      ST_IIR1, ST_IIR2: stage_on = c.iir_filter_enable;
      ST_DIR:   stage_on = c.input_direction_select;
      ST_CHK, ST_GAIN, ST_CLAMP: stage_on = c.short_stroke_enable;
      ST_HARM:  stage_on = c.harmonic_lin_enable;
      ST_SEG:   stage_on = c.segmented_lin_enable;
      ST_FLIP:  stage_on = c.final_polarity_flip;
      ST_INV:   stage_on = c.short_stroke_enable && c.inversion_enable;
      ST_DIE:   stage_on = c.die_adjust_enable;
      ST_IDLE:  stage_on = 1'b0;
      default:  stage_on = 1'b1;
    endcase
  endfunction

  function automatic appc_st_e step_next(input appc_st_e s, input appc_cfg_s c);
    appc_st_e n;
    logic     done;
    n    = s;
    done = 1'b0;
    for (int k = 0; k < ST_COUNT; k++) begin
      if (!done && n != ST_PUSH) begin
        n    = appc_st_e'(int'(n) + 1);
        done = stage_on(n, c); // [RULE20]
      end
    end
    step_next = n;
  endfunction

  // Conversion request timer
  logic [SAMPLE_CNT_W-1:0] smp_cnt;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      smp_cnt           <= '0;
      fe_sample_req_out <= 1'b0;
    end else if (smp_cnt == SAMPLE_CNT_W'(SAMPLE_CYC - 1)) begin
      smp_cnt           <= '0;
      fe_sample_req_out <= 1'b1; // [RULE2]
    end else begin
      smp_cnt           <= smp_cnt + 1'b1;
      fe_sample_req_out <= 1'b0;
    end
  end

  // Decimation by two and band-pass per channel
  logic signed [15:0] ch_in [2];
  logic signed [15:0] ch_bp [2];
  logic               dec_ph;
  logic               cond_valid;

  assign ch_in[0] = fe_sample_in.x;
  assign ch_in[1] = fe_sample_in.y;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dec_ph     <= 1'b0;
      cond_valid <= 1'b0;
    end else begin
      cond_valid <= fe_valid_in && dec_ph; // [RULE18]
      if (fe_valid_in) begin
        dec_ph <= !dec_ph;
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_cond
    logic signed [15:0] first;
    logic signed [15:0] dc;
    logic signed [16:0] sum;
    logic signed [15:0] lp;
    logic signed [16:0] dif;

    assign sum = {first[15], first} + {ch_in[g][15], ch_in[g]};
    assign lp  = sum[16:1];
    assign dif = {lp[15], lp} - {dc[15], dc};

    always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        first    <= '0;
        dc       <= '0;
        ch_bp[g] <= '0;
      end else if (fe_valid_in) begin
        if (!dec_ph) begin
          first <= ch_in[g];
        end else begin
          // Low-pass by pair sum, high-pass by tracked DC removal
          dc       <= dc + 16'(dif >>> DC_SH); // [RULE18]
          ch_bp[g] <= dif[16:1];
        end
      end
    end
  end

  // Sequential vectoring rotation for the raw angle
  logic [4:0]         cor_i;
  logic               cor_busy;
  logic signed [17:0] cx;
  logic signed [17:0] cy;
  logic [15:0]        cz;
  logic [15:0]        next_z;
  logic               raw_valid;
  logic [15:0]        raw_angle;

  assign next_z = cy[17] ? 16'(cz - ATAN[cor_i[3:0]]) : 16'(cz + ATAN[cor_i[3:0]]);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cor_i     <= '0;
      cor_busy  <= 1'b0;
      cx        <= '0;
      cy        <= '0;
      cz        <= '0;
      raw_valid <= 1'b0;
      raw_angle <= '0;
    end else begin
      raw_valid <= 1'b0;
      if (!cor_busy && cond_valid) begin
        cor_busy <= 1'b1;
        cor_i    <= '0;
        if (ch_bp[0][15]) begin
          cx <= -18'(ch_bp[0]);
          cy <= -18'(ch_bp[1]);
          cz <= Z_HALF;
        end else begin
          cx <= 18'(ch_bp[0]);
          cy <= 18'(ch_bp[1]);
          cz <= '0;
        end
      end else if (cor_busy) begin
        cz <= next_z;
        if (cy[17]) begin
          cx <= cx - (cy >>> cor_i);
          cy <= cy + (cx >>> cor_i);
        end else begin
          cx <= cx + (cy >>> cor_i);
          cy <= cy - (cx >>> cor_i);
        end
        cor_i <= cor_i + 1'b1;
        if (cor_i == 5'(CORDIC_N - 1)) begin
          cor_busy  <= 1'b0;
          raw_valid <= 1'b1; // [RULE19]
          raw_angle <= next_z;
        end
      end
    end
  end

  // Averaging relative to the first sample keeps wrap-around intact
  logic [7:0]         avg_cnt;
  logic [7:0]         avg_need;
  logic [15:0]        avg_first;
  logic [15:0]        avg_base;
  logic signed [23:0] avg_acc;
  logic signed [15:0] avg_d;
  logic signed [23:0] avg_sum;
  logic               pend_valid;
  logic [15:0]        pend_angle;

  assign avg_need = 8'h01 << cfg_in.averaging_rate_select; // [RULE1]
  assign avg_base = (avg_cnt == 8'h00) ? raw_angle : avg_first;
  assign avg_d    = raw_angle - avg_base;
  assign avg_sum  = ((avg_cnt == 8'h00) ? 24'sd0 : avg_acc) + 24'(avg_d);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avg_cnt   <= '0;
      avg_first <= '0;
      avg_acc   <= '0;
    end else if (raw_valid) begin
      avg_first <= avg_base;
      avg_acc   <= avg_sum;
      if (8'(avg_cnt + 8'h01) >= avg_need) begin
        avg_cnt <= '0; // [RULE1]
      end else begin
        avg_cnt <= avg_cnt + 1'b1;
      end
    end
  end

  // Latest average waits here while the chain is busy
  logic     take;
  appc_st_e st;

  assign take = (st == ST_IDLE) && pend_valid;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_valid <= 1'b0;
      pend_angle <= '0;
    end else if (raw_valid && 8'(avg_cnt + 8'h01) >= avg_need) begin
      pend_valid <= 1'b1; // [RULE2]
      pend_angle <= avg_base + 16'(avg_sum >>> cfg_in.averaging_rate_select); // [RULE1]
    end else if (take) begin
      pend_valid <= 1'b0;
    end
  end

  // Temperature compensation coefficients
  appc_tc_s tc;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tc <= '{slope: TC_SLOPE_DEF, ref_temp: TC_REF_DEF}; // [RULE4]
    end else if (tc_load_in) begin
      tc <= tc_in;
    end
  end

  // Harmonic terms
  logic [15:0]        ang;
  logic signed [31:0] hterm [HARM_N];

  for (genvar h = 0; h < HARM_N; h++) begin : g_harm
    logic [15:0] ph;
    assign ph       = 16'(ang * 16'(h + 1));
    assign hterm[h] = $signed(correction_coefficients_in[h]) * sin16(ph[15:12]); // [RULE9]
  end

  // Post-processing datapath
  logic [11:0]        o12;
  logic [15:0]        next_ang;
  logic [11:0]        next_o12;
  logic signed [15:0] iir1;
  logic signed [15:0] iir2;
  logic signed [28:0] tprod;
  logic [31:0]        gprod;
  logic signed [33:0] hsum;
  logic [3:0]         seg;
  logic signed [16:0] sdif;
  logic signed [29:0] sprod;
  logic               fifo_ready;

  always_comb begin
    next_ang = ang;
    next_o12 = o12;
    hsum     = '0;
    for (int h = 0; h < HARM_N; h++) begin
      hsum = hsum + 34'(hterm[h]);
    end
    tprod = $signed({temperature_in[11], temperature_in} - {tc.ref_temp[11], tc.ref_temp})
            * tc.slope;
    gprod = ang * lim_in.gain;
    seg   = ang[15:12];
    sdif  = $signed({correction_coefficients_in[4'(seg + 4'h1)][15],
                     correction_coefficients_in[4'(seg + 4'h1)]})
            - $signed({correction_coefficients_in[seg][15], correction_coefficients_in[seg]});
    sprod = sdif * $signed({1'b0, ang[11:0]});
    case (st)
      ST_IDLE:  next_ang = pend_angle;
      ST_IIR1:  next_ang = 16'(iir1 + 16'($signed(ang - iir1) >>> cfg_in.iir_shift1)); // [RULE3]
      ST_IIR2:  next_ang = 16'(iir2 + 16'($signed(ang - iir2) >>> cfg_in.iir_shift2)); // [RULE3]
      ST_TEMP:  next_ang = ang - 16'(tprod >>> TC_FRAC); // [RULE4]
      ST_DIR:   next_ang = 16'(-ang); // [RULE5]
      ST_OFS:   next_ang = ang - zero_in.pre_scale_zero; // [RULE6] [RULE21]
      ST_GAIN:  next_ang = ((gprod >> GAIN_FRAC) > 32'h0000ffff) ? 16'hffff
                           : gprod[GAIN_FRAC +: 16]; // [RULE8]
      ST_HARM:  next_ang = ang + 16'(hsum >>> SIN_SH); // [RULE9]
      ST_LZERO: next_ang = ang - zero_in.pre_linearize_zero; // [RULE10] [RULE21]
      ST_SEG:   next_ang = ang + correction_coefficients_in[seg]
                           + 16'(sprod >>> SEG_SH); // [RULE11]
      ST_PZERO: next_ang = ang - zero_in.post_linearize_zero; // [RULE12] [RULE21]
      ST_FLIP:  next_ang = 16'(-ang); // [RULE13]
      ST_CLAMP: begin
        if (ang > lim_in.output_upper_limit) begin
          next_ang = lim_in.output_upper_limit; // [RULE14]
        end else if (ang < lim_in.output_lower_limit) begin
          next_ang = lim_in.output_lower_limit; // [RULE14]
        end
      end
      ST_ROUND: next_o12 = round12(ang); // [RULE15] [RULE22]
      ST_INV:   next_o12 = round12(lim_in.output_upper_limit)
                           - (o12 - round12(lim_in.output_lower_limit)); // [RULE16]
      ST_DIE:   next_o12 = o12 + HALF_TURN; // [RULE17] [RULE21]
      default:  next_ang = ang;
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st  <= ST_IDLE;
      ang <= '0;
      o12 <= '0;
    end else begin
      ang <= next_ang;
      o12 <= next_o12;
      case (st)
        ST_IDLE: begin
          if (take) begin
            st <= step_next(ST_IDLE, cfg_in);
          end
        end
        ST_PUSH: begin
          // Full buffer stalls the chain here
          if (fifo_ready) begin
            st <= ST_IDLE;
          end
        end
        default: st <= step_next(st, cfg_in); // [RULE20]
      endcase
    end
  end

  // Filter state persists across refreshes
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      iir1 <= '0;
      iir2 <= '0;
    end else begin
      if (st == ST_IIR1) begin
        iir1 <= next_ang;
      end
      if (st == ST_IIR2) begin
        iir2 <= next_ang;
      end
    end
  end

  // Sticky range flags; a new violation wins over a clear
  logic hi_hit;
  logic lo_hit;

  assign hi_hit = (st == ST_CHK) && (ang > lim_in.stroke_upper_bound); // [RULE7]
  assign lo_hit = (st == ST_CHK) && (ang < lim_in.stroke_lower_bound); // [RULE7]

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      angle_above_limit_flag_out <= 1'b0;
      angle_below_limit_flag_out <= 1'b0;
    end else begin
      angle_above_limit_flag_out <= hi_hit || (angle_above_limit_flag_out && !fault_clear_in);
      angle_below_limit_flag_out <= lo_hit || (angle_below_limit_flag_out && !fault_clear_in);
    end
  end

  appc_fifo #(
    .WIDTH (OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (st == ST_PUSH),
    .in_data_in    (o12),
    .in_ready_out  (fifo_ready),
    .out_valid_out (angle_valid_out),
    .out_data_out  (angle_out),
    .out_ready_in  (angle_ready_in)
  );

endmodule // appc_chain

`default_nettype wire

// ---- verilog/appc_pkg.sv ----
package appc_pkg;

  localparam int ANG_W      = 16;
  localparam int OUT_W      = 12;
  localparam int RND_SH     = ANG_W - OUT_W;
  localparam logic [15:0] RND_HALF  = 16'h0008;
  localparam logic [11:0] HALF_TURN = 12'h800;
  localparam logic [15:0] Z_HALF    = 16'h8000;

  localparam int CLK_KHZ         = 20000;
  localparam int REFRESH_BASE_US = 32;
  localparam int DECIM           = 2;
  localparam int SAMPLE_CYC      = REFRESH_BASE_US * CLK_KHZ / 1000 / DECIM;
  localparam int SAMPLE_CNT_W    = 9;

  localparam int DC_SH     = 6;
  localparam int CORDIC_N  = 16;
  localparam int GAIN_FRAC = 12;
  localparam int TC_FRAC   = 12;
  localparam int SEG_SH    = 12;
  localparam int HARM_N    = 4;
  localparam int SIN_SH    = 15;
  localparam int COEF_N    = 16;
  localparam int FIFO_DEPTH = 8;

  // Factory compensation defaults
  localparam logic [15:0] TC_SLOPE_DEF = 16'h0000;
  localparam logic [11:0] TC_REF_DEF   = 12'h019;

  localparam logic [15:0] ATAN [0:15] = '{
    16'h2000, 16'h12e4, 16'h09fb, 16'h0511, 16'h028b, 16'h0146, 16'h00a3, 16'h0051,
    16'h0029, 16'h0014, 16'h000a, 16'h0005, 16'h0003, 16'h0001, 16'h0001, 16'h0000};
  localparam logic [15:0] SIN_Q [0:4] = '{
    16'h0000, 16'h30fb, 16'h5a82, 16'h7641, 16'h7fff};

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
  } appc_fe_s;

  typedef struct packed {
    logic [2:0] averaging_rate_select;
    logic       iir_filter_enable;
    logic [2:0] iir_shift1;
    logic [2:0] iir_shift2;
    logic       input_direction_select;
    logic       short_stroke_enable;
    logic       harmonic_lin_enable;
    logic       segmented_lin_enable;
    logic       final_polarity_flip;
    logic       inversion_enable;
    logic       die_adjust_enable;
  } appc_cfg_s;

  typedef struct packed {
    logic [15:0] pre_scale_zero;
    logic [15:0] pre_linearize_zero;
    logic [15:0] post_linearize_zero;
  } appc_zero_s;

  typedef struct packed {
    logic [15:0] stroke_lower_bound;
    logic [15:0] stroke_upper_bound;
    logic [15:0] output_lower_limit;
    logic [15:0] output_upper_limit;
    logic [15:0] gain;
  } appc_lim_s;

  typedef struct packed {
    logic signed [15:0] slope;
    logic signed [11:0] ref_temp;
  } appc_tc_s;

  typedef logic [COEF_N-1:0][15:0] appc_coef_t;

  typedef enum {
    ST_IDLE, ST_IIR1, ST_IIR2, ST_TEMP, ST_DIR, ST_OFS, ST_CHK, ST_GAIN, ST_HARM,
    ST_LZERO, ST_SEG, ST_PZERO, ST_FLIP, ST_CLAMP, ST_ROUND, ST_INV, ST_DIE, ST_PUSH
  } appc_st_e;

  localparam int ST_COUNT = 18;

endpackage

// ---- bench/appc_chain_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none

module appc_chain_monitor (
  // Clock and reset
  input wire logic                mclk_in,
  input wire logic                resetn_in,
  // Watched ports
  input wire logic                fe_sample_req_out,
  input wire appc_pkg::appc_cfg_s cfg_in,
  input wire appc_pkg::appc_lim_s lim_in,
  input wire logic                fault_clear_in,
  input wire logic                angle_above_limit_flag_out,
  input wire logic                angle_below_limit_flag_out,
  input wire logic [11:0]         angle_out,
  input wire logic                angle_valid_out,
  input wire logic                angle_ready_in
);
  import appc_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  property p_req_pulse;
    fe_sample_req_out |=> !fe_sample_req_out [*8];
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request pulse not isolated");

  // Counter stands in for a long delay, which the tools would unroll
  logic [8:0] req_gap;
  logic       req_seen;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_gap  <= 9'h000;
      req_seen <= 1'b0;
    end else if (fe_sample_req_out) begin
      req_gap  <= 9'h001;
      req_seen <= 1'b1;
    end else if (req_gap != 9'h1ff) begin
      req_gap <= req_gap + 9'h001;
    end
  end

  property p_req_period;
    req_seen |-> (fe_sample_req_out ? req_gap == 9'(SAMPLE_CYC) : req_gap < 9'(SAMPLE_CYC));
  endproperty
  a_req_period: assert property (p_req_period)
    else $error("request period wrong");

  property p_valid_hold;
    angle_valid_out && !angle_ready_in |=> angle_valid_out;
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("valid dropped before taken");

  property p_data_hold;
    angle_valid_out && !angle_ready_in |=> $stable(angle_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("angle changed before taken");

  property p_above_sticky;
    angle_above_limit_flag_out && !fault_clear_in |=> angle_above_limit_flag_out;
  endproperty
  a_above_sticky: assert property (p_above_sticky)
    else $error("above flag lost without clear");

  property p_below_sticky;
    angle_below_limit_flag_out && !fault_clear_in |=> angle_below_limit_flag_out;
  endproperty
  a_below_sticky: assert property (p_below_sticky)
    else $error("below flag lost without clear");

  property p_flag_mode;
    $rose(angle_above_limit_flag_out) || $rose(angle_below_limit_flag_out)
      |-> $past(cfg_in.short_stroke_enable);
  endproperty
  a_flag_mode: assert property (p_flag_mode)
    else $error("flag set outside short stroke");

  // Limits kept on 16-code steps so the rounded bound is the top slice
  property p_clamp;
    angle_valid_out && cfg_in.short_stroke_enable && !cfg_in.inversion_enable
      && !cfg_in.die_adjust_enable |-> angle_out >= lim_in.output_lower_limit[15:4]
      && angle_out <= lim_in.output_upper_limit[15:4];
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("angle outside clamp limits");
endmodule // appc_chain_monitor

bind appc_chain appc_chain_monitor u_mon (
  .mclk_in                    (mclk_in),
  .resetn_in                  (resetn_in),
  .fe_sample_req_out          (fe_sample_req_out),
  .cfg_in                     (cfg_in),
  .lim_in                     (lim_in),
  .fault_clear_in             (fault_clear_in),
  .angle_above_limit_flag_out (angle_above_limit_flag_out),
  .angle_below_limit_flag_out (angle_below_limit_flag_out),
  .angle_out                  (angle_out),
  .angle_valid_out            (angle_valid_out),
  .angle_ready_in             (angle_ready_in)
);
`default_nettype wire

// ---- bench/appc_reader.sv ----
`timescale 1ns/10ps
`default_nettype none

module appc_reader (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        resetn_in,
  // Angle stream
  input wire logic [11:0] angle_in,
  input wire logic        valid_in,
  output logic            ready_out,
  // Control and record
  input wire logic        stall_in,
  output var int          count_out,
  output var int          gap_out,
  output logic [11:0]     word_out
);
  int t;
  // Gap counts edges between takes, so refresh spacing is exact
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_out <= 1'h0;
      count_out <= 0;
      gap_out   <= 0;
      word_out  <= 12'h000;
      t         <= 0;
    end else begin
      ready_out <= !stall_in;
      t         <= t + 1;
      if (valid_in && ready_out) begin
        count_out <= count_out + 1;
        word_out  <= angle_in;
        gap_out   <= t;
        t         <= 1;
      end
    end
  end
endmodule // appc_reader
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import appc_pkg::*;
  typedef struct packed {
    logic        f;
    logic        i;
    logic        d;
    logic        m;
    logic [15:0] lz;
    logic [15:0] pz;
    logic [11:0] e;
  } appc_row_s;

  logic        mclk_in = 1'h0;
  logic        resetn_in = 1'h0;
  logic        fv = 1'h0;
  logic        tcl = 1'h0;
  logic        fclr = 1'h0;
  logic        stall = 1'h0;
  logic [11:0] temp = 12'h040;
  appc_fe_s    fe = {16'h4000, 16'h2000};
  appc_cfg_s   cfg = '0;
  appc_zero_s  zr = '0;
  appc_lim_s   lim = {16'h0000, 16'hffff, 16'h1000, 16'h6000, 16'h0000};
  appc_tc_s    tc = {16'h0100, 12'h020};
  appc_coef_t  coef = '0;
  logic        req, above, below, vld, rdy;
  logic [11:0] ang, wd;
  int          cnt, gap;
  int          mismatches = 0;
  int          tests_run = 0;
  int          c0;
  // Gain zero makes the chain output a known function of the row's offsets and flags only
  appc_row_s   rows [10] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h0000, 12'h100},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'hd000, 12'h300},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'he000, 16'hf800, 12'h280},
    '{1'h1, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h3000, 12'h300},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'hd008, 12'h300},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'hd009, 12'h2ff},
    '{1'h0, 1'h1, 1'h0, 1'h0, 16'h0000, 16'hd000, 12'h400},
    '{1'h0, 1'h0, 1'h1, 1'h0, 16'h0000, 16'hd000, 12'hb00},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h9000, 12'h600},
    '{1'h0, 1'h0, 1'h0, 1'h1, 16'h0000, 16'hd000, 12'h310}
  };

  always #25 mclk_in = ~mclk_in;
  // Front end answers each request one cycle later
  always @(posedge mclk_in) fv <= #1 req;

  appc_chain dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .fe_sample_req_out(req),
    .fe_valid_in(fv), .fe_sample_in(fe), .temperature_in(temp), .cfg_in(cfg),
    .zero_in(zr), .lim_in(lim), .correction_coefficients_in(coef), .tc_load_in(tcl),
    .tc_in(tc), .fault_clear_in(fclr), .angle_above_limit_flag_out(above),
    .angle_below_limit_flag_out(below), .angle_out(ang), .angle_valid_out(vld),
    .angle_ready_in(rdy)
  );

  appc_reader u_rd (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .angle_in(ang), .valid_in(vld),
    .ready_out(rdy), .stall_in(stall), .count_out(cnt), .gap_out(gap), .word_out(wd)
  );

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task words(input int n);
    int s;
    s = cnt;
    for (int k = 0; k < 20000 && cnt < s + n; k++) @(posedge mclk_in);
    if (cnt < s + n) begin
      mismatches++;
      $display("Error at %0t: no angle word", $time);
    end
    #1;
  endtask

  task row_set(input appc_row_s r);
    cfg.final_polarity_flip    = r.f;
    cfg.inversion_enable       = r.i;
    cfg.die_adjust_enable      = r.d;
    cfg.iir_filter_enable      = r.m;
    cfg.harmonic_lin_enable    = r.m;
    cfg.segmented_lin_enable   = r.m;
    cfg.input_direction_select = r.m;
    // Segment 0 start error shows up since gain zero leaves the angle at 0
    coef[0] = r.m ? 16'h0100 : 16'h0000;
    zr = {r.pz, r.lz, r.pz};
  endtask

  initial begin
    cfg.short_stroke_enable = 1'h1;
    cfg.iir_shift1 = 3'h2;
    cfg.iir_shift2 = 3'h3;
    repeat (12) @(posedge mclk_in);
    #1 resetn_in = 1'h1;
    check(vld, 16'h0000);
    check(above | below, 16'h0000);
    tcl = 1'h1;
    @(posedge mclk_in);
    #1 tcl = 1'h0;
    foreach (rows[k]) begin
      row_set(rows[k]);
      words(2);
      check(wd, rows[k].e);
    end
    for (int c = 0; c < 4; c++) begin
      cfg.averaging_rate_select = c[2:0];
      words(3);
      check(gap[15:0], 16'd640 << c);
    end
    cfg.averaging_rate_select = 3'h0;
    words(2);
    lim.stroke_lower_bound = 16'hffff;
    words(2);
    check({below, above}, 16'h0002);
    fclr = 1'h1;
    lim.stroke_lower_bound = 16'h0000;
    words(1);
    fclr = 1'h0;
    lim.stroke_upper_bound = 16'h0000;
    check(below, 16'h0000);
    words(2);
    check({below, above}, 16'h0001);
    lim.stroke_upper_bound = 16'hffff;
    fclr = 1'h1;
    @(posedge mclk_in);
    #1 fclr = 1'h0;
    check(above, 16'h0000);
    stall = 1'h1;
    repeat (2) @(posedge mclk_in);
    #1 c0 = cnt;
    repeat (8000) @(posedge mclk_in);
    #1 check(vld, 16'h0001);
    check(cnt[15:0], c0[15:0]);
    stall = 1'h0;
    repeat (40) @(posedge mclk_in);
    #1 check(cnt[15:0] - c0[15:0], 16'h000b);
    check(wd, 16'h0310);
    summarize();
  end

  initial begin
    #4000000;
    mismatches++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
